// ### bench/swcfg_host_model.sv
/*
  Host controller model: issues whole 16-bit register commands and
  collects the read answer and the unmapped flag.
  Assumes the bank takes a command on the edge with cmd_valid high.
*/
`timescale 1ns/1ps

module swcfg_host_model (
  input wire logic core_clk,
  input wire swcfg_pkg::swcfg_byte_t rd_data,
  input wire logic rd_valid,
  input wire logic cmd_unmapped,
  output logic cmd_valid,
  output swcfg_pkg::swcfg_cmd_t cmd_word
);
  import swcfg_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end

  // data comes from the caller unchanged
  task automatic xfer(input logic [6:0] addr, input logic wr, input swcfg_byte_t data,
                      output swcfg_byte_t rdat, output logic got, output logic unm);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_word <= {data, wr, addr};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    // Idle word inverted so a stale command is never mistaken for a fresh one
    cmd_word <= ~{data, wr, addr};
    // The bank takes the word on this edge; its unmapped flag stands one cycle only
    #1 unm = cmd_unmapped;
    @(posedge core_clk);
    #1 got = rd_valid;
    rdat = rd_data;
  endtask
endmodule

// ### bench/swcfg_regs_tb.sv
/*
  Self-checking bench of the selective wake configuration bank.
  Assumes the host model drives the command port, the bench the rest.
*/
`timescale 1ns/1ps
`include "swcfg_defines.svh"

module swcfg_regs_tb;
  import swcfg_pkg::*;
  logic core_clk, rst_n, cmd_valid, rd_valid, cmd_unmapped;
  logic silence_expired, rx_raw, rx_filtered, error_counter_run;
  logic analog_filter_bypass, fd_tolerant_enable, wake_receiver_select;
  logic [1:0] trim_unlock;
  swcfg_cmd_t cmd_word;
  swcfg_byte_t rd_data, cal_value_in, rv;
  swcfg_byte_t payload_byte_three, payload_byte_two, payload_byte_one, payload_byte_zero;
  swcfg_ftime_t dominant_filter_time;
  swcfg_trim_t oscillator_trim_value;
  logic gv, uv;
  int n_errors = 0;
  int n_tests = 0;

  swcfg_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_unmapped(cmd_unmapped), .trim_unlock(trim_unlock),
    .silence_expired(silence_expired), .cal_value_in(cal_value_in), .rx_raw(rx_raw),
    .rx_filtered(rx_filtered), .payload_byte_three(payload_byte_three),
    .payload_byte_two(payload_byte_two), .payload_byte_one(payload_byte_one),
    .payload_byte_zero(payload_byte_zero), .error_counter_run(error_counter_run),
    .analog_filter_bypass(analog_filter_bypass),
    .dominant_filter_time(dominant_filter_time), .fd_tolerant_enable(fd_tolerant_enable),
    .oscillator_trim_value(oscillator_trim_value),
    .wake_receiver_select(wake_receiver_select));

  swcfg_host_model u_host (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_unmapped(cmd_unmapped), .cmd_valid(cmd_valid), .cmd_word(cmd_word));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic results();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s", $time, msg);
      n_errors++;
    end
  endtask

  task automatic rd(input logic [6:0] a, output swcfg_byte_t v);
    logic g, u;
    u_host.xfer(a, 1'b0, 8'h00, v, g, u);
    chk({7'h00, g}, 8'h01, "read answer missing");
  endtask

  task automatic wr(input logic [6:0] a, input swcfg_byte_t d);
    swcfg_byte_t v;
    logic g, u;
    u_host.xfer(a, 1'b1, d, v, g, u);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rd(7'h30 + 7'(i), rv);
      chk(rv, 8'h00, "payload or fd reset value");
    end
    rd(`SWCFG_ADDR_OPTIONS, rv);
    chk(rv, 8'h00, "options reset value");
    rd(`SWCFG_ADDR_OSC_TRIM, rv);
    chk(rv, 8'h40, "trim preset value");
    rd(`SWCFG_ADDR_CAL_HIGH, rv);
    chk(rv, 8'h00, "calibration reset value");
  endtask

  task automatic t_payload();
    wr(`SWCFG_ADDR_PAYLOAD3, 8'h01);
    wr(`SWCFG_ADDR_PAYLOAD2, 8'h80);
    wr(`SWCFG_ADDR_PAYLOAD1, 8'hA5);
    wr(`SWCFG_ADDR_PAYLOAD0, 8'h3C);
    chk(payload_byte_three, 8'h01, "payload three lsb");
    chk(payload_byte_two, 8'h80, "payload two msb");
    chk(payload_byte_one, 8'hA5, "payload one");
    chk(payload_byte_zero, 8'h3C, "payload zero");
    rd(`SWCFG_ADDR_PAYLOAD2, rv);
    chk(rv, 8'h80, "payload two readback");
  endtask

  task automatic t_fdcfg();
    wr(`SWCFG_ADDR_FD_CFG, 8'hFF);
    rd(`SWCFG_ADDR_FD_CFG, rv);
    chk(rv, 8'h3F, "fd top bits not zero");
    chk({7'h00, error_counter_run}, 8'h00, "counter not stopped");
    chk({7'h00, analog_filter_bypass}, 8'h01, "bypass bit");
    for (int c = 0; c < 8; c++) begin
      wr(`SWCFG_ADDR_FD_CFG, {4'h0, 3'(c), 1'b0});
      chk({5'h00, dominant_filter_time}, 8'(c), "filter time code");
      chk({7'h00, fd_tolerant_enable}, 8'h00, "fd enable clear");
    end
    wr(`SWCFG_ADDR_FD_CFG, 8'h20);
    chk({7'h00, error_counter_run}, 8'h01, "counter stopped without fd");
    wr(`SWCFG_ADDR_FD_CFG, 8'h01);
    chk({7'h00, error_counter_run}, 8'h01, "counter stopped without disable");
    chk({7'h00, fd_tolerant_enable}, 8'h01, "fd enable set");
  endtask

  task automatic t_silence();
    wr(`SWCFG_ADDR_FD_CFG, 8'h21);
    @(posedge core_clk) silence_expired <= 1'b1;
    @(posedge core_clk) silence_expired <= 1'b0;
    rd(`SWCFG_ADDR_FD_CFG, rv);
    chk(rv, 8'h01, "disable bit not cleared");
    chk({7'h00, error_counter_run}, 8'h01, "counter still stopped");
  endtask

  task automatic t_lock();
    @(posedge core_clk) trim_unlock <= 2'h2;
    wr(`SWCFG_ADDR_OSC_TRIM, 8'h15);
    chk({1'b0, oscillator_trim_value}, 8'h40, "locked trim write stored");
    wr(`SWCFG_ADDR_OPTIONS, 8'h80);
    chk({7'h00, wake_receiver_select}, 8'h00, "locked select write stored");
    @(posedge core_clk) trim_unlock <= `SWCFG_UNLOCK_KEY;
    wr(`SWCFG_ADDR_OSC_TRIM, 8'h15);
    chk({1'b0, oscillator_trim_value}, 8'h15, "unlocked trim write lost");
    wr(`SWCFG_ADDR_OPTIONS, 8'hE0);
    chk({7'h00, wake_receiver_select}, 8'h01, "standard receiver select");
    rd(`SWCFG_ADDR_OPTIONS, rv);
    chk(rv, 8'h80, "options reserved bits");
    wr(`SWCFG_ADDR_OSC_TRIM, 8'h40);
  endtask

  task automatic t_misc();
    u_host.xfer(7'h35, 1'b0, 8'h00, rv, gv, uv);
    chk({7'h00, uv}, 8'h01, "unmapped flag missing");
    chk(rv, 8'h00, "unmapped read data");
    @(posedge core_clk) cal_value_in <= 8'hC3;
    rd(`SWCFG_ADDR_CAL_HIGH, rv);
    chk(rv, 8'hC3, "calibration readback");
  endtask

  task automatic t_filter(input logic [2:0] code);
    int t;
    int n;
    t = (code == 3'h7) ? 28 : 2 * (int'(code) + 1);
    wr(`SWCFG_ADDR_FD_CFG, {3'h0, 1'b1, code, 1'b1});
    @(posedge core_clk) rx_raw <= 1'b0;
    n = 0;
    while (n < 40) begin
      @(posedge core_clk);
      #1 n++;
      if (rx_filtered === 1'b0) break;
    end
    chk({7'h00, n >= t && n <= t + 1}, 8'h01, "dominant filter delay");
    @(posedge core_clk) rx_raw <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h00, rx_filtered}, 8'h01, "filter release");
  endtask

  task automatic t_rerun();
    wr(`SWCFG_ADDR_PAYLOAD0, 8'h5A);
    @(posedge core_clk) rst_n <= 1'b0;
    cal_value_in <= 8'h00;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    chk(payload_byte_zero, 8'h00, "payload kept through reset");
    t_reset();
  endtask

  initial begin
    repeat (6000) @(posedge core_clk);
    n_errors++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    silence_expired = 1'b0;
    rx_raw = 1'b1;
    trim_unlock = 2'h0;
    cal_value_in = 8'h00;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_payload();
    t_fdcfg();
    t_silence();
    t_lock();
    t_misc();
    t_filter(3'h0);
    t_filter(3'h7);
    t_rerun();
    results();
  end
endmodule

// ### src/swcfg_cmd_decode.sv
/*
  Registered decoder of one 16-bit register command into index,
  write and read pulses and write data.
  Assumes commands arrive as whole words with a one-cycle valid.
*/
`timescale 1ns/1ps
`include "swcfg_defines.svh"

module swcfg_cmd_decode (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire swcfg_pkg::swcfg_cmd_t cmd_word,
  output logic wr_pulse,
  output logic rd_pulse,
  output logic hit,
  output swcfg_pkg::swcfg_idx_t idx,
  output swcfg_pkg::swcfg_byte_t wdata,
  output logic unmapped
);
  import swcfg_pkg::*;

  localparam logic [6:0] ADDRS [8] = '{`SWCFG_ADDR_PAYLOAD3, `SWCFG_ADDR_PAYLOAD2,
    `SWCFG_ADDR_PAYLOAD1, `SWCFG_ADDR_PAYLOAD0, `SWCFG_ADDR_FD_CFG,
    `SWCFG_ADDR_OSC_TRIM, `SWCFG_ADDR_OPTIONS, `SWCFG_ADDR_CAL_HIGH};

  logic [7:0] hit_vec;
  logic any_hit;
  swcfg_idx_t idx_next;

  for (genvar i = 0; i < 8; i++) begin : g_match
    assign hit_vec[i] = (cmd_word[`SWCFG_CMD_ADDR_MSB:0] == ADDRS[i]);
  end

  assign any_hit = |hit_vec;

  always_comb begin
    idx_next = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (hit_vec[i]) begin
        idx_next = 3'(i);
      end
    end
  end

  // mode bit splits read and write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      hit <= 1'b0;
      unmapped <= 1'b0;
    end else begin
      wr_pulse <= cmd_valid && cmd_word[`SWCFG_CMD_MODE_BIT] && any_hit;
      rd_pulse <= cmd_valid && !cmd_word[`SWCFG_CMD_MODE_BIT];
      hit <= any_hit;
      unmapped <= cmd_valid && !any_hit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 3'h0;
      wdata <= 8'h00;
    end else if (cmd_valid) begin
      idx <= idx_next;
      wdata <= cmd_word[`SWCFG_CMD_DATA_MSB:`SWCFG_CMD_DATA_LSB];
    end
  end
endmodule

// ### src/swcfg_defines.svh
/*
  Offsets, field positions, reset values and timing figures of the
  selective wake configuration bank.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef SWCFG_DEFINES_SVH
`define SWCFG_DEFINES_SVH

`define SWCFG_ADDR_PAYLOAD3 7'h30
`define SWCFG_ADDR_PAYLOAD2 7'h31
`define SWCFG_ADDR_PAYLOAD1 7'h32
`define SWCFG_ADDR_PAYLOAD0 7'h33
`define SWCFG_ADDR_FD_CFG 7'h34
`define SWCFG_ADDR_OSC_TRIM 7'h38
`define SWCFG_ADDR_OPTIONS 7'h39
`define SWCFG_ADDR_CAL_HIGH 7'h3A

`define SWCFG_IDX_FD_CFG 3'h4
`define SWCFG_IDX_OSC_TRIM 3'h5
`define SWCFG_IDX_OPTIONS 3'h6
`define SWCFG_IDX_CAL_HIGH 3'h7

`define SWCFG_CMD_ADDR_MSB 6
`define SWCFG_CMD_MODE_BIT 7
`define SWCFG_CMD_DATA_MSB 15
`define SWCFG_CMD_DATA_LSB 8

`define SWCFG_FD_ECD_BIT 5
`define SWCFG_FD_BYP_BIT 4
`define SWCFG_FD_FT_MSB 3
`define SWCFG_FD_FT_LSB 1
`define SWCFG_FD_EN_BIT 0
`define SWCFG_TRIM_MSB 6
`define SWCFG_TRIM_RSVD_BIT 7
`define SWCFG_OPT_SEL_BIT 7
`define SWCFG_OPT_RSVD_MSB 4

`define SWCFG_UNLOCK_KEY 2'h3

`define SWCFG_PAYLOAD_RST 8'h00
`define SWCFG_FD_ECD_RST 1'h0
`define SWCFG_FD_BYP_RST 1'h0
`define SWCFG_FD_FT_RST 3'h0
`define SWCFG_FD_EN_RST 1'h0
`define SWCFG_OPT_SEL_RST 1'h0
`define SWCFG_CAL_RST 8'h00
`define SWCFG_FT_LONG_CODE 3'h7

`define SWCFG_CLK_MHZ 40
`define SWCFG_FILT_STEP_NS 50
`define SWCFG_FILT_LONG_NS 700

`endif

// ### src/swcfg_dom_filter.sv
/*
  Digital dominant filter for the FD tolerant receive path.
  Assumes rx_raw is synchronous to core_clk, low meaning dominant.
*/
`timescale 1ns/1ps
`include "swcfg_defines.svh"

module swcfg_dom_filter #(
  parameter int CNT_W = 5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic filter_enable,
  input wire swcfg_pkg::swcfg_ftime_t filter_time,
  input wire logic rx_raw,
  output logic rx_filtered
);
  import swcfg_pkg::*;

  localparam int STEP_CYC = (`SWCFG_FILT_STEP_NS * `SWCFG_CLK_MHZ + 999) / 1000;
  localparam int LONG_CYC = (`SWCFG_FILT_LONG_NS * `SWCFG_CLK_MHZ + 999) / 1000;

  if (LONG_CYC >= (1 << CNT_W) || STEP_CYC < 1) begin : g_bad_width
    $error("dominant filter counter too narrow");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] thr;

  always_comb begin
    if (filter_time == `SWCFG_FT_LONG_CODE) begin
      thr = CNT_W'(LONG_CYC);
    end else begin
      thr = CNT_W'((int'(filter_time) + 1) * STEP_CYC);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      rx_filtered <= 1'b1;
    end else if (!filter_enable || rx_raw) begin
      cnt_reg <= '0;
      rx_filtered <= rx_raw;
    end else if (cnt_reg >= thr - CNT_W'(1)) begin
      rx_filtered <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_FILT_SHORT: assert property (
    filter_enable && $past(filter_enable) && $fell(rx_filtered)
      |-> !$past(rx_raw) && !$past(rx_raw, 2))
    else $error("dominant passed in under the shortest filter time");
  AST_FILT_LONG: assert property (
    filter_enable && filter_time == 3'h7 && $stable(filter_time)
      && $past(filter_enable, 28) && $fell(rx_filtered)
      |-> !$past(rx_raw, 28) && $past(filter_time, 28) == 3'h7)
    else $error("long filter time not kept");
  COV_FILT_PASS: cover property (filter_enable && $fell(rx_filtered));
endmodule

// ### src/swcfg_pkg.sv
/*
  Types shared by the selective wake configuration bank.
  Assumes nothing beyond the defines header.
*/
package swcfg_pkg;
  typedef logic [7:0] swcfg_byte_t;
  typedef logic [15:0] swcfg_cmd_t;
  typedef logic [2:0] swcfg_idx_t;
  typedef logic [2:0] swcfg_ftime_t;
  typedef logic [6:0] swcfg_trim_t;
endpackage

// ### src/swcfg_regs.sv
/*
  Selective wake configuration bank: payload bytes, FD tolerant controls,
  oscillator trim, wake receiver select and calibration readback.
  Assumes whole 16-bit commands from an outside serial engine, and a
  trim unlock field, silence timeout and calibration value from elsewhere.
*/
`timescale 1ns/1ps
`include "swcfg_defines.svh"

// What this block does
// - Each payload register holds one expected wake byte, bit 0 least significant.
// - Reset loads zero into all payload bytes and the FD configuration.
// - Top two FD configuration bits read zero, also after restart.
// - Reserved read-only bits of the bank always read zero.
// - Error counter stops only when its disable and FD tolerant mode are set.
// - Bus silence timeout clears the error counter disable bit.
// - Bypass bit skips the analog filter; digital dominant filter stays.
// - Filter code 0 to 6 gives 50 to 350 ns, code 7 gives 700 ns.
// - FD bit 0 enables FD tolerant mode.
// - Trim value is writable only while unlock field is binary 11.
// - Receiver select writable only when unlocked; 0 low-power, 1 standard.
// - Calibration high register reads the oscillator calibration, zero after reset.
// - Options register resets with bits 7 to 5 clear, low-power receiver.
// - Each access is one 16-bit command: address, mode bit, data byte.
module swcfg_regs #(
  parameter logic [4:0] OPT_RSVD_PRESET = 5'h00,
  parameter logic TRIM_RSVD_PRESET = 1'b0,
  parameter logic [6:0] TRIM_PRESET = 7'h40
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire swcfg_pkg::swcfg_cmd_t cmd_word,
  output swcfg_pkg::swcfg_byte_t rd_data,
  output logic rd_valid,
  output logic cmd_unmapped,
  input wire logic [1:0] trim_unlock,
  input wire logic silence_expired,
  input wire swcfg_pkg::swcfg_byte_t cal_value_in,
  input wire logic rx_raw,
  output logic rx_filtered,
  output swcfg_pkg::swcfg_byte_t payload_byte_three,
  output swcfg_pkg::swcfg_byte_t payload_byte_two,
  output swcfg_pkg::swcfg_byte_t payload_byte_one,
  output swcfg_pkg::swcfg_byte_t payload_byte_zero,
  output logic error_counter_run,
  output logic analog_filter_bypass,
  output swcfg_pkg::swcfg_ftime_t dominant_filter_time,
  output logic fd_tolerant_enable,
  output swcfg_pkg::swcfg_trim_t oscillator_trim_value,
  output logic wake_receiver_select
);
  import swcfg_pkg::*;

  logic wr_pulse;
  logic rd_pulse;
  logic hit;
  swcfg_idx_t idx;
  swcfg_byte_t wdata;
  swcfg_byte_t payload_reg [4];
  logic error_counter_disable_reg;
  logic trim_rsvd_reg;
  logic [4:0] opt_rsvd_reg;
  swcfg_byte_t cal_reg;
  swcfg_byte_t rmux;
  logic unlocked;
  logic fd_we;
  logic trim_we;
  logic opt_we;

  swcfg_cmd_decode u_decode (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cmd_valid(cmd_valid),
    .cmd_word(cmd_word),
    .wr_pulse(wr_pulse),
    .rd_pulse(rd_pulse),
    .hit(hit),
    .idx(idx),
    .wdata(wdata),
    .unmapped(cmd_unmapped)
  );

  assign unlocked = (trim_unlock == `SWCFG_UNLOCK_KEY);
  assign fd_we = wr_pulse && (idx == `SWCFG_IDX_FD_CFG);
  assign trim_we = wr_pulse && (idx == `SWCFG_IDX_OSC_TRIM);
  assign opt_we = wr_pulse && (idx == `SWCFG_IDX_OPTIONS);

  for (genvar i = 0; i < 4; i++) begin : g_payload
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        payload_reg[i] <= `SWCFG_PAYLOAD_RST;
      end else if (wr_pulse && idx == 3'(i)) begin
        payload_reg[i] <= wdata;
      end
    end
  end

  assign payload_byte_three = payload_reg[0];
  assign payload_byte_two = payload_reg[1];
  assign payload_byte_one = payload_reg[2];
  assign payload_byte_zero = payload_reg[3];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_filter_bypass <= `SWCFG_FD_BYP_RST;
      dominant_filter_time <= `SWCFG_FD_FT_RST;
      fd_tolerant_enable <= `SWCFG_FD_EN_RST;
    end else if (fd_we) begin
      analog_filter_bypass <= wdata[`SWCFG_FD_BYP_BIT];
      dominant_filter_time <= wdata[`SWCFG_FD_FT_MSB:`SWCFG_FD_FT_LSB];
      fd_tolerant_enable <= wdata[`SWCFG_FD_EN_BIT];
    end
  end

  // silence timeout clears disable
  // The timeout beats a write in the same cycle: the bus has gone quiet.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_counter_disable_reg <= `SWCFG_FD_ECD_RST;
    end else if (silence_expired) begin
      error_counter_disable_reg <= 1'b0;
    end else if (fd_we) begin
      error_counter_disable_reg <= wdata[`SWCFG_FD_ECD_BIT];
    end
  end

  assign error_counter_run = !(error_counter_disable_reg && fd_tolerant_enable);

  // trim writes need the unlock key
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_trim_value <= TRIM_PRESET;
    end else if (trim_we && unlocked) begin
      oscillator_trim_value <= wdata[`SWCFG_TRIM_MSB:0];
    end
  end

  // Reserved read-write fields keep what is written; software must not touch them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_rsvd_reg <= TRIM_RSVD_PRESET;
      opt_rsvd_reg <= OPT_RSVD_PRESET;
    end else begin
      if (trim_we) begin
        trim_rsvd_reg <= wdata[`SWCFG_TRIM_RSVD_BIT];
      end
      if (opt_we) begin
        opt_rsvd_reg <= wdata[`SWCFG_OPT_RSVD_MSB:0];
      end
    end
  end

  // receiver select needs the unlock key
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_receiver_select <= `SWCFG_OPT_SEL_RST;
    end else if (opt_we && unlocked) begin
      wake_receiver_select <= wdata[`SWCFG_OPT_SEL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_reg <= `SWCFG_CAL_RST;
    end else begin
      cal_reg <= cal_value_in;
    end
  end

  always_comb begin
    rmux = 8'h00;
    case (idx)
      3'h0: rmux = payload_reg[0];
      3'h1: rmux = payload_reg[1];
      3'h2: rmux = payload_reg[2];
      3'h3: rmux = payload_reg[3];
      3'h4: rmux = {2'h0, error_counter_disable_reg, analog_filter_bypass,
        dominant_filter_time, fd_tolerant_enable};
      3'h5: rmux = {trim_rsvd_reg, oscillator_trim_value};
      3'h6: rmux = {wake_receiver_select, 2'h0, opt_rsvd_reg};
      3'h7: rmux = cal_reg;
      default: rmux = 8'h00;
    endcase
  end

  // read answer one cycle after decode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_pulse;
      if (rd_pulse) begin
        rd_data <= hit ? rmux : 8'h00;
      end
    end
  end

  swcfg_dom_filter #(
    .CNT_W(5)
  ) u_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .filter_enable(fd_tolerant_enable),
    .filter_time(dominant_filter_time),
    .rx_raw(rx_raw),
    .rx_filtered(rx_filtered)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_PAYLOAD_WRITE: assert property (
    cmd_valid && cmd_word[7:0] == 8'hB0 |-> ##2 payload_byte_three == $past(cmd_word[15:8], 2))
    else $error("payload byte three not written");
  AST_RESET_ZERO: assert property (
    $rose(rst_n) |-> payload_byte_zero == 8'h00 && payload_byte_three == 8'h00
      && !fd_tolerant_enable && dominant_filter_time == 3'h0 && !analog_filter_bypass)
    else $error("reset values not zero");
  AST_FD_TOP_ZERO: assert property (
    rd_valid && $past(idx) == 3'h4 && $past(hit) |-> rd_data[7:6] == 2'h0)
    else $error("fd config top bits not zero");
  AST_OPT_RSVD_ZERO: assert property (
    rd_valid && $past(idx) == 3'h6 && $past(hit) |-> rd_data[6:5] == 2'h0)
    else $error("options reserved bits not zero");
  AST_ERRCNT_STOP: assert property (
    fd_we && wdata[5] && wdata[0] && !silence_expired |=> !error_counter_run)
    else $error("error counter not stopped");
  AST_SILENCE_CLEAR: assert property (
    silence_expired |=> !error_counter_disable_reg ##0 error_counter_run)
    else $error("silence timeout did not clear disable");
  AST_BYPASS_WRITE: assert property (
    fd_we |=> analog_filter_bypass == $past(wdata[4]))
    else $error("bypass bit not stored");
  AST_FD_ENABLE: assert property (
    cmd_valid && cmd_word[7:0] == 8'hB4 |-> ##2 fd_tolerant_enable == $past(cmd_word[8], 2))
    else $error("fd tolerant enable not stored");
  AST_TRIM_UNLOCKED: assert property (
    trim_we && unlocked |=> oscillator_trim_value == $past(wdata[6:0]))
    else $error("unlocked trim write lost");
  AST_TRIM_LOCKED: assert property (
    trim_we && !unlocked |=> $stable(oscillator_trim_value))
    else $error("locked trim write took effect");
  AST_SEL_LOCKED: assert property (
    opt_we && !unlocked |=> $stable(wake_receiver_select))
    else $error("locked receiver select changed");
  AST_CAL_READ: assert property (
    rd_valid && $past(idx) == 3'h7 && $past(hit) |-> rd_data == $past(cal_value_in, 2))
    else $error("calibration readback wrong");
  AST_OPT_RESET: assert property (
    $rose(rst_n) |-> !wake_receiver_select)
    else $error("receiver select not low-power after reset");
  AST_READ_LATENCY: assert property (
    cmd_valid && !cmd_word[7] |-> !rd_valid ##1 !rd_valid ##1 rd_valid)
    else $error("read answer not two cycles after command");
  AST_NO_READ_ON_WRITE: assert property (
    cmd_valid && cmd_word[7]
      |-> ##2 !rd_valid)
    else $error("write command produced a read answer");
  AST_UNMAPPED_WRITE: assert property (
    cmd_valid && cmd_word[6:4] != 3'h3
      |=> cmd_unmapped && !wr_pulse)
    else $error("unmapped command not flagged or not dropped");
  AST_UNMAPPED_READ: assert property (
    rd_valid && !$past(hit)
      |-> rd_data == 8'h00)
    else $error("unmapped read returned data");
  AST_PAYLOAD_TWO: assert property (
    cmd_valid && cmd_word[7:0] == 8'hB1
      |-> ##2 payload_byte_two == $past(cmd_word[15:8], 2))
    else $error("payload byte two not written");
  AST_PAYLOAD_ONE: assert property (
    cmd_valid && cmd_word[7:0] == 8'hB2
      |-> ##2 payload_byte_one == $past(cmd_word[15:8], 2))
    else $error("payload byte one not written");
  AST_PAYLOAD_ZERO: assert property (
    cmd_valid && cmd_word[7:0] == 8'hB3
      |-> ##2 payload_byte_zero == $past(cmd_word[15:8], 2))
    else $error("payload byte zero not written");
  AST_PAYLOAD_HOLD: assert property (
    !wr_pulse
      |=> $stable(payload_byte_three) && $stable(payload_byte_zero))
    else $error("payload byte changed without a write");
  AST_FT_WRITE: assert property (
    fd_we
      |=> dominant_filter_time == $past(wdata[3:1]))
    else $error("filter time code not stored");
  AST_ERRCNT_RUN: assert property (
    fd_we && !(wdata[5] && wdata[0])
      |=> error_counter_run)
    else $error("error counter stopped without both bits");
  AST_FD_HOLD: assert property (
    !fd_we && !silence_expired
      |=> $stable(fd_tolerant_enable) && $stable(error_counter_disable_reg))
    else $error("fd configuration changed without a write");
  AST_TRIM_HOLD: assert property (
    !trim_we
      |=> $stable(oscillator_trim_value))
    else $error("trim value changed without a write");
  AST_SEL_UNLOCKED: assert property (
    opt_we && unlocked
      |=> wake_receiver_select == $past(wdata[7]))
    else $error("unlocked receiver select write lost");
  AST_SEL_HOLD: assert property (
    !opt_we
      |=> $stable(wake_receiver_select))
    else $error("receiver select changed without a write");
  AST_CAL_RESET: assert property (
    $rose(rst_n)
      |-> cal_reg == 8'h00 && rd_data == 8'h00)
    else $error("calibration not zero after reset");
  // Read answers hold the register state seen at the edge that loaded rd_data
  AST_RD_FD_FIELDS: assert property (
    rd_valid && $past(idx) == 3'h4 && $past(hit)
      |-> rd_data[5:0] == $past({error_counter_disable_reg, analog_filter_bypass,
        dominant_filter_time, fd_tolerant_enable}))
    else $error("fd configuration readback wrong");
  AST_RD_TRIM: assert property (
    rd_valid && $past(idx) == 3'h5 && $past(hit)
      |-> rd_data[6:0] == $past(oscillator_trim_value))
    else $error("trim readback wrong");
  AST_RD_SEL: assert property (
    rd_valid && $past(idx) == 3'h6 && $past(hit)
      |-> rd_data[7] == $past(wake_receiver_select))
    else $error("receiver select readback wrong");

  COV_PAYLOAD_READ: cover property (rd_valid && $past(idx) == 3'h0 && rd_data != 8'h00);
  COV_UNLOCKED_SEL: cover property (opt_we && unlocked ##1 wake_receiver_select);
  COV_SILENCE: cover property (error_counter_disable_reg ##1 silence_expired);
  COV_UNMAPPED: cover property (cmd_unmapped);
endmodule
